// ---- src/fco_command_regs.v ----
// Command object array, launch flag and option mirror behind an Avalon-MM slave
//
// Overview of operation
// RL1 - Option mirror is read-only; bus writes never change it.
// RL2 - Option mirror is loaded from nonvolatile option bits during reset sequence.
// RL3 - Twelve byte-wide command object registers, index 0 through B.
// RL4 - Command bytes accept writes in any order; software fills all needed.
// RL5 - Writing one to the complete flag launches the command.
// RL6 - Launch clears the complete flag; bytes locked while it stays clear.
// RL7 - No command queueing; next command loads only after completion.
// RL8 - Controller may write results back; software reads after flag returns.
// RL9 - Byte zero is always the command code.
// RL10 - Command code is eight bits and alone selects the operation.
// RL11 - Bytes after the code carry that command's parameters.
// RL12 - Bytes 1-3 hold flash address high to low; bytes 4+ data.
// RL13 - Command bytes reset to zero; writes while locked are silently ignored.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fco_map.vh"

module fco_command_regs (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [7:0]  nonvolatile_option_bits,
  output wire        command_start,
  output wire [7:0]  command_code_byte,
  output wire [23:0] command_flash_address,
  output wire [63:0] command_data_bytes,
  output wire        command_complete_flag,
  input  wire        engine_done,
  input  wire        engine_result_we,
  input  wire [3:0]  engine_result_index,
  input  wire [7:0]  engine_result_data
);

  localparam NB = `FCO_NUM_CMD_BYTES;

  // One-hot bus states: idle, then one answer cycle
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK  = 2'b10;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [7:0]  cmd_bytes_q [0:NB-1];
  reg         ccf_q;
  wire [7:0]  option_byte_mirror;
  wire        option_loaded;
  wire        req;
  wire        wr_take;
  wire        rd_take;
  wire [3:0]  idx;
  wire        launch;
  reg  [7:0]  rd_byte;

  assign req = avs_read | avs_write;
  assign idx = avs_address[3:0];

  always @*
  begin
    case (state_q)
      // Hold off answers until the option mirror holds the captured byte
      ST_IDLE: state_d = (req & option_loaded) ? ST_ACK : ST_IDLE;
      ST_ACK:  state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Stall one cycle so every access completes in the ACK state
  assign avs_waitrequest = req & (state_q != ST_ACK);
  assign wr_take         = avs_write & (state_q == ST_ACK);
  assign rd_take         = avs_read  & (state_q == ST_ACK);

  // RL2 capture of nonvolatile option bits
  fco_option_loader u_opt (
    .clk                  (clk),
    .rst_n                (rst_n),
    .nv_option_bits       (nonvolatile_option_bits),
    .option_byte_mirror_q (option_byte_mirror),
    .option_loaded_q      (option_loaded)
  );

  // RL5 write of one launches
  assign launch = wr_take & (avs_address == {2'b00, `FCO_IDX_STATUS}) & avs_byteenable[0]
                  & avs_writedata[`FCO_STATUS_CCF_BIT] & ccf_q;
  assign command_start = launch;

  // RL6 launch clears flag; engine done sets it
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ccf_q <= 1'b1;
    else if (engine_done & ~ccf_q)
      ccf_q <= 1'b1;
    else if (launch)
      ccf_q <= 1'b0;
  end
  assign command_complete_flag = ccf_q;

  // RL3 twelve command bytes
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1)
    begin : g_cmd
      localparam [5:0] BYTE_ADDR = `FCO_IDX_CMD_BASE + g;
      localparam [3:0] BYTE_IDX  = g;
      wire hit = (avs_address == BYTE_ADDR) & avs_byteenable[0];
      always @(posedge clk or negedge rst_n)
      begin
        // RL13 reset to zero
        if (!rst_n)
          cmd_bytes_q[g] <= `FCO_CMD_RESET;
        // RL8 controller results while running
        else if (~ccf_q & engine_result_we & (engine_result_index == BYTE_IDX))
          cmd_bytes_q[g] <= engine_result_data;
        // RL4 RL7 RL13 any order, only while complete
        else if (wr_take & hit & ccf_q)
          cmd_bytes_q[g] <= avs_writedata[7:0];
      end
    end
  endgenerate

  // RL9 RL10 byte zero is the code
  assign command_code_byte     = cmd_bytes_q[`FCO_POS_CODE];
  // RL11 RL12 address then data bytes
  assign command_flash_address = {cmd_bytes_q[`FCO_POS_ADDR_HI],
                                  cmd_bytes_q[`FCO_POS_ADDR_MID],
                                  cmd_bytes_q[`FCO_POS_ADDR_LO]};
  assign command_data_bytes    = {cmd_bytes_q[11], cmd_bytes_q[10], cmd_bytes_q[9],
                                  cmd_bytes_q[8], cmd_bytes_q[7], cmd_bytes_q[6],
                                  cmd_bytes_q[5], cmd_bytes_q[`FCO_POS_DATA0]};

  // RL1 option mirror has read path only
  always @*
  begin
    rd_byte = 8'h00;
    if (avs_address == {2'b00, `FCO_IDX_STATUS})
      rd_byte = {ccf_q, 7'h00};
    else if (avs_address == {2'b00, `FCO_IDX_OPTION})
      rd_byte = option_byte_mirror;
    else if ((avs_address >= {2'b00, `FCO_IDX_CMD_BASE}) && (avs_address < 6'd16))
      rd_byte = cmd_bytes_q[idx - `FCO_IDX_CMD_BASE];
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= `FCO_READ_ZERO;
    else if (req & option_loaded & (state_q == ST_IDLE) & avs_read)
      avs_readdata <= {24'h000000, rd_byte};
  end

endmodule // fco_command_regs
`default_nettype wire

// ---- src/fco_map.vh ----
// Register offsets, field layout and reset values of the flash command object block
`ifndef FCO_MAP_VH
`define FCO_MAP_VH

// Printed offsets are byte indexes; byte address is four times the index
`define FCO_IDX_STATUS        4'h0
`define FCO_IDX_OPTION        4'h3
`define FCO_IDX_CMD_BASE      4'h4
`define FCO_NUM_CMD_BYTES     12
`define FCO_IDX_WIDTH         4
`define FCO_ADDR_WIDTH        6
`define FCO_STATUS_CCF_BIT    7
`define FCO_CMD_RESET         8'h00
`define FCO_OPTION_PRELOAD    8'hFF
`define FCO_READ_ZERO         32'h0000_0000
// Generic layout: byte 0 code, bytes 1..3 address, bytes 4.. data
`define FCO_POS_CODE          0
`define FCO_POS_ADDR_HI       1
`define FCO_POS_ADDR_MID      2
`define FCO_POS_ADDR_LO       3
`define FCO_POS_DATA0         4

`endif

// ---- src/fco_option_loader.v ----
// Option byte mirror loaded from nonvolatile storage at reset release
`timescale 1ns/1ps
`default_nettype none
`include "fco_map.vh"

module fco_option_loader (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] nv_option_bits,
  output reg  [7:0] option_byte_mirror_q,
  output reg        option_loaded_q
);

  // Reset holds a constant; the real byte is captured on the first edge after release
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      option_byte_mirror_q <= `FCO_OPTION_PRELOAD;
      option_loaded_q      <= 1'b0;
    end
    else if (!option_loaded_q)
    begin
      option_byte_mirror_q <= nv_option_bits;
      option_loaded_q      <= 1'b1;
    end
  end

endmodule // fco_option_loader
`default_nettype wire

// ---- dv/fco_props.sv ----
// Bus timing, launch and lock checks for the command object block
`timescale 1ns/1ps
`default_nettype none
module fco_props (
  input wire logic clk, rst_n, avs_read, avs_write, avs_waitrequest, command_start,
  input wire logic command_complete_flag, engine_done, engine_result_we,
  input wire logic [5:0] avs_address,
  input wire logic [31:0] avs_writedata, avs_readdata,
  input wire logic [3:0] avs_byteenable, engine_result_index,
  input wire logic [7:0] nonvolatile_option_bits, command_code_byte, engine_result_data,
  input wire logic [23:0] command_flash_address,
  input wire logic [63:0] command_data_bytes
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  one_wait_a: assert property ((avs_read | avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer after one wait");
  launch_cause_a: assert property (command_start |-> avs_write && !avs_waitrequest
    && avs_address == 6'h00 && avs_writedata[7] && command_complete_flag) else $error("bad start");
  launch_clears_a: assert property (command_start |=> !command_complete_flag)
    else $error("flag not cleared");
  bytes_locked_a: assert property (!command_complete_flag && !engine_result_we |=>
    $stable({command_code_byte, command_flash_address, command_data_bytes})) else $error("lock");
  done_sets_a: assert property (engine_done && !command_complete_flag |=> command_complete_flag)
    else $error("flag not set");
  flag_holds_a: assert property (command_complete_flag && !command_start |=>
    command_complete_flag) else $error("flag dropped");
  code_write_a: assert property (avs_write && !avs_waitrequest && avs_address == 6'h04
    && avs_byteenable[0] && command_complete_flag |=>
    command_code_byte == $past(avs_writedata[7:0])) else $error("code byte");
  result_back_a: assert property (engine_result_we && engine_result_index == 4'h4
    && !command_complete_flag |=> command_data_bytes[7:0] == $past(engine_result_data))
    else $error("result byte");
  option_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h03
    |-> avs_readdata == {24'h0, nonvolatile_option_bits}) else $error("option byte");
endmodule // fco_props
bind fco_command_regs fco_props i_props (.*);
`default_nettype wire

// ---- dv/tb.sv ----
// Register-level tests of the command object block over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, engine_done = 1'b0;
  logic engine_result_we = 1'b0, avs_waitrequest, command_start, command_complete_flag;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hF, engine_result_index = 4'h0;
  logic [7:0] nonvolatile_option_bits = 8'h5A, engine_result_data = 8'h00, command_code_byte;
  logic [23:0] command_flash_address;
  logic [63:0] command_data_bytes;
  int bad_count = 0, n_tests = 0;
  always #2 clk = ~clk;
  fco_command_regs i_dut (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Request rises after an edge and holds until waitrequest is sampled low at a rising edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    // No answer within the bound counts as a mismatch
    if (avs_waitrequest !== 1'b0)
      bad_count++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #20000;
    bad_count++;
    finish_test;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(6'h03, 8'h5A);
    acc(1'b1, 6'h03, 8'hA5);
    rd(6'h03, 8'h5A);
    rd(6'h01, 8'h00);
    for (int i = 0; i < 12; i++)
      rd(6'(i + 4), 8'h00);
    for (int i = 11; i >= 0; i--)
      acc(1'b1, 6'(i + 4), 8'(i + 16));
    for (int i = 0; i < 12; i++)
      rd(6'(i + 4), 8'(i + 16));
    chk({24'h0, command_code_byte}, 32'h10);
    chk({8'h0, command_flash_address}, 32'h111213);
    chk(command_data_bytes[63:32], 32'h1B1A1918);
    $display("test fill done");
    rd(6'h00, 8'h80);
    acc(1'b1, 6'h00, 8'h80);
    rd(6'h00, 8'h00);
    acc(1'b1, 6'h04, 8'hFF);
    rd(6'h04, 8'h10);
    engine_result_we <= 1'b1;
    engine_result_index <= 4'h4;
    engine_result_data <= 8'h77;
    @(posedge clk);
    engine_result_we <= 1'b0;
    engine_done <= 1'b1;
    @(posedge clk);
    engine_done <= 1'b0;
    rd(6'h00, 8'h80);
    rd(6'h08, 8'h77);
    acc(1'b1, 6'h04, 8'h22);
    rd(6'h04, 8'h22);
    $display("test launch done");
    finish_test;
  end
endmodule // tb
`default_nettype wire
